// ---- peripheral_clock_gate_run_sleep.v ----
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_defines.vh"

// Contract
// - each implemented gating bit is the clock enable of one unit, one meaning clocked.
// - an access to a unit whose clock is gated off answers with a bus fault.
// - both gating registers clear to all zeros at reset.
// - run register applies in run, sleep register in sleep, deep-sleep register in deep sleep.
// - sleep settings are used only when the automatic gating bit is set.
// - ports a to g sit on bits 0 to 6, read and write.
// - mac enable on bit 28, phy enable on bit 30, bits 29 and 31 reserved.
// - bits 27 to 7 are read-only zero; software preserves them.
// - run register at 0x108, sleep register at 0x118.
module peripheral_clock_gate_run_sleep #(
    parameter UNITS = 9
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // power mode from the power controller, and the deep-sleep enables
    input wire [1:0] power_mode,
    input wire [31:0] deep_sleep_gate_reg,
    // unit access monitor: one select per unit, read or write strobe
    input wire [UNITS-1:0] unit_access_sel,
    input wire unit_access_write,
    output reg unit_access_fault,
    // gated clocks and enables, bits 0-6 ports a-g, 7 mac, 8 phy
    output wire [UNITS-1:0] unit_clk,
    output reg [UNITS-1:0] unit_clk_en,
    output reg irq
);
    // ****************************************
    // registers
    // ****************************************
    reg [31:0] run_gate_reg;
    reg [31:0] sleep_gate_reg;
    reg auto_gating_select;
    reg [2:0] fault_status;
    reg [2:0] fault_mask;
    reg [1:0] mode_seen;
    reg [31:0] active_gate;
    reg [UNITS-1:0] next_unit_clk_en;
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] strb_mask;
    reg [31:0] read_value;
    reg read_ok;
    reg wr_ok;
    reg [2:0] fault_set;
    integer i;

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && !s_axi_rvalid;
    wire status_read = do_read && (s_axi_araddr == `FAULT_STATUS_OFFSET);

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // ****************************************
    // active enable set
    // ****************************************
    always @*
    begin
        if (power_mode == `MODE_DEEP_SLEEP)
        begin
            active_gate = deep_sleep_gate_reg;
        end
        else if (power_mode == `MODE_SLEEP && auto_gating_select)
        begin
            active_gate = sleep_gate_reg;
        end
        else
        begin
            // without automatic gating, sleep keeps the run set
            active_gate = run_gate_reg;
        end
        next_unit_clk_en[6:0] = active_gate[`GATE_PORT_MSB:`GATE_PORT_LSB];
        next_unit_clk_en[7] = active_gate[`GATE_MAC_BIT];
        next_unit_clk_en[8] = active_gate[`GATE_PHY_BIT];
    end

    // ****************************************
    // per-unit clock gates
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < UNITS; g = g + 1)
        begin : gate_gen
            unit_clock_gate u_gate (
                .clk_in(aclk),
                .enable(unit_clk_en[g]),
                .clk_out(unit_clk[g])
            );
        end
    endgenerate

    // ****************************************
    // write decode
    // ****************************************
    always @*
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            strb_mask[i*8 +: 8] = {8{w_strb[i]}};
        end
        wr_ok = 1'b1;
        if (aw_addr == `RUN_GATE_OFFSET)
        begin
            wr_ok = 1'b1;
        end
        else if (aw_addr == `SLEEP_GATE_OFFSET)
        begin
            wr_ok = 1'b1;
        end
        else if (aw_addr == `AUTO_GATING_OFFSET)
        begin
            wr_ok = 1'b1;
        end
        else if (aw_addr == `FAULT_MASK_OFFSET)
        begin
            wr_ok = 1'b1;
        end
        else if (aw_addr == `FAULT_STATUS_OFFSET || aw_addr == `POWER_MODE_OFFSET)
        begin
            wr_ok = 1'b1;
        end
        else
        begin
            wr_ok = 1'b0;
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    always @*
    begin
        read_value = 32'h00000000;
        read_ok = 1'b1;
        if (s_axi_araddr == `RUN_GATE_OFFSET)
        begin
            read_value = run_gate_reg;
        end
        else if (s_axi_araddr == `SLEEP_GATE_OFFSET)
        begin
            read_value = sleep_gate_reg;
        end
        else if (s_axi_araddr == `AUTO_GATING_OFFSET)
        begin
            read_value[`AUTO_GATING_BIT] = auto_gating_select;
        end
        else if (s_axi_araddr == `POWER_MODE_OFFSET)
        begin
            read_value[1:0] = mode_seen;
        end
        else if (s_axi_araddr == `FAULT_STATUS_OFFSET)
        begin
            read_value[2:0] = fault_status;
        end
        else if (s_axi_araddr == `FAULT_MASK_OFFSET)
        begin
            read_value[2:0] = fault_mask;
        end
        else
        begin
            read_ok = 1'b0;
        end
    end

    // ****************************************
    // fault events
    // ****************************************
    always @*
    begin
        fault_set = 3'h0;
        if (|(unit_access_sel & ~unit_clk_en))
        begin
            fault_set[`FAULT_WRITE_BIT] = unit_access_write;
            fault_set[`FAULT_READ_BIT] = !unit_access_write;
        end
        fault_set[`FAULT_MODE_BIT] = (power_mode != mode_seen);
    end

    // ****************************************
    // sequential state
    // ****************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_gate_reg <= `GATE_RESET;
            sleep_gate_reg <= `GATE_RESET;
            auto_gating_select <= `AUTO_GATING_RESET;
            fault_status <= 3'h0;
            fault_mask <= 3'h0;
            mode_seen <= `MODE_RUN;
            unit_clk_en <= {UNITS{1'b0}};
            unit_access_fault <= 1'b0;
            irq <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            // enable set registered so mode changes land on a clock edge
            unit_clk_en <= next_unit_clk_en;
            mode_seen <= power_mode;
            unit_access_fault <= |(unit_access_sel & ~unit_clk_en);
            irq <= |(fault_status & fault_mask);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                // reserved bits never take a value
                if (aw_addr == `RUN_GATE_OFFSET)
                begin
                    run_gate_reg <= (run_gate_reg & ~(strb_mask & `GATE_WRITABLE_MASK))
                        | (w_data & strb_mask & `GATE_WRITABLE_MASK);
                end
                else if (aw_addr == `SLEEP_GATE_OFFSET)
                begin
                    sleep_gate_reg <= (sleep_gate_reg & ~(strb_mask & `GATE_WRITABLE_MASK))
                        | (w_data & strb_mask & `GATE_WRITABLE_MASK);
                end
                else if (aw_addr == `AUTO_GATING_OFFSET && w_strb[0])
                begin
                    auto_gating_select <= w_data[`AUTO_GATING_BIT];
                end
                else if (aw_addr == `FAULT_MASK_OFFSET && w_strb[0])
                begin
                    fault_mask <= w_data[2:0];
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_value;
                s_axi_rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
            // a new event in the clearing cycle survives the read
            fault_status <= (status_read ? 3'h0 : fault_status) | fault_set;
        end
    end
endmodule // peripheral_clock_gate_run_sleep

`default_nettype wire

// ---- clock_gate_defines.vh ----
`ifndef CLOCK_GATE_DEFINES_VH
`define CLOCK_GATE_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define RUN_GATE_OFFSET 12'h108
`define SLEEP_GATE_OFFSET 12'h118
`define AUTO_GATING_OFFSET 12'h200
`define POWER_MODE_OFFSET 12'h204
`define FAULT_STATUS_OFFSET 12'h210
`define FAULT_MASK_OFFSET 12'h214

// ****************************************
// field positions and masks
// ****************************************
`define GATE_PORT_LSB 0
`define GATE_PORT_MSB 6
`define GATE_MAC_BIT 28
`define GATE_PHY_BIT 30
`define GATE_WRITABLE_MASK 32'h5000007F
`define GATE_RESET 32'h00000000
`define AUTO_GATING_BIT 0
`define AUTO_GATING_RESET 1'b0

// ****************************************
// power modes and status bits
// ****************************************
`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP_SLEEP 2'h2
`define FAULT_READ_BIT 0
`define FAULT_WRITE_BIT 1
`define FAULT_MODE_BIT 2

// ****************************************
// axi response codes
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- unit_clock_gate.v ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// glitch-free clock gate
// ****************************************
module unit_clock_gate (
    input wire clk_in,
    input wire enable,
    output wire clk_out
);
    reg enable_latched;

    // taken on the falling edge: steady while clock is high, so no runt pulse escapes
    always @(negedge clk_in)
    begin
        enable_latched <= enable;
    end

    assign clk_out = clk_in & enable_latched;
endmodule // unit_clock_gate

`default_nettype wire

// ---- peripheral_clock_gate_run_sleep_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module clock_gate_checker #(
    parameter UNITS = 9
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] power_mode,
    input wire [31:0] deep_sleep_gate_reg,
    input wire [UNITS-1:0] unit_access_sel,
    input wire [UNITS-1:0] unit_clk_en,
    input wire unit_access_fault
);
    // ****************************************
    // bus, fault and enable relations
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_fault;
        1 |=> unit_access_fault == $past(|(unit_access_sel & ~unit_clk_en));
    endproperty
    a_fault: assert property (p_fault) else $error("fault mismatch");
    // reset itself is checked, so no disable here
    property p_reset;
        disable iff (1'b0) !aresetn |=> unit_clk_en == 0 && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_deep;
        power_mode == 2'h2 && $past(power_mode) == 2'h2 && $past(power_mode, 2) == 2'h2
            && $stable(deep_sleep_gate_reg) && $past(deep_sleep_gate_reg) ==
            $past(deep_sleep_gate_reg, 2) |-> unit_clk_en ==
            {deep_sleep_gate_reg[30], deep_sleep_gate_reg[28], deep_sleep_gate_reg[6:0]};
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep enables wrong");
    property p_arready;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_arready: assert property (p_arready) else $error("read answer without request");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
endmodule // clock_gate_checker
bind peripheral_clock_gate_run_sleep clock_gate_checker #(.UNITS(UNITS)) u_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .power_mode(power_mode), .deep_sleep_gate_reg(deep_sleep_gate_reg),
    .unit_access_sel(unit_access_sel), .unit_clk_en(unit_clk_en),
    .unit_access_fault(unit_access_fault));
`default_nettype wire

// ---- peripheral_clock_gate_run_sleep_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_defines.vh"
module peripheral_clock_gate_run_sleep_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, deep = 32'h00000000;
    logic [1:0] mode = 2'h0;
    logic [8:0] sel = 9'h000;
    logic sel_wr = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, fault, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [8:0] uclk, en;
    int mismatches = 0;
    int num_checks = 0;
    peripheral_clock_gate_run_sleep u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_mode(mode), .deep_sleep_gate_reg(deep), .unit_access_sel(sel),
        .unit_access_write(sel_wr), .unit_access_fault(fault), .unit_clk(uclk),
        .unit_clk_en(en), .irq(irq));
    // ****************************************
    // clock, tasks
    // ****************************************
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    // fault stands for one cycle only, so look right after it lands
    task automatic hit(input logic [8:0] s, input logic w, input logic e);
        @(posedge aclk);
        sel <= s;
        sel_wr <= w;
        @(posedge aclk);
        sel <= 9'h000;
        #1;
        chk(fault, e);
    endtask
    // enables are registered after the mode mux, then latched by the gate, hence three edges
    task automatic settle(input logic [31:0] e, input logic which);
        repeat (3) @(posedge aclk);
        #1;
        chk(which ? irq : en, e);
        // clock is high here, so each gated clock shows its enable
        if (!which)
            chk(uclk, e);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        final_report;
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RUN_GATE_OFFSET, `GATE_RESET, `RESP_OKAY);
        rd(`SLEEP_GATE_OFFSET, `GATE_RESET, `RESP_OKAY);
        settle(9'h000, 1'b0);
        hit(9'h001, 1'b0, 1'b1);
        wr(`FAULT_MASK_OFFSET, 32'h00000007, `RESP_OKAY);
        settle(1'b1, 1'b1);
        rd(`FAULT_STATUS_OFFSET, 32'h00000001, `RESP_OKAY);
        settle(1'b0, 1'b1);
        wr(`RUN_GATE_OFFSET, 32'hFFFFFFFF, `RESP_OKAY);
        rd(`RUN_GATE_OFFSET, 32'h5000007F, `RESP_OKAY);
        settle(9'h1FF, 1'b0);
        hit(9'h100, 1'b1, 1'b0);
        wr(`RUN_GATE_OFFSET, 32'h10000005, `RESP_OKAY);
        settle(9'h085, 1'b0);
        wr(`FAULT_MASK_OFFSET, 32'h00000000, `RESP_OKAY);
        hit(9'h002, 1'b1, 1'b1);
        settle(1'b0, 1'b1);
        rd(`FAULT_STATUS_OFFSET, 32'h00000002, `RESP_OKAY);
        wr(`SLEEP_GATE_OFFSET, 32'hC0000001, `RESP_OKAY);
        rd(`SLEEP_GATE_OFFSET, 32'h40000001, `RESP_OKAY);
        @(posedge aclk);
        mode <= `MODE_SLEEP;
        settle(9'h085, 1'b0);
        wr(`AUTO_GATING_OFFSET, 32'h00000001, `RESP_OKAY);
        settle(9'h101, 1'b0);
        @(posedge aclk);
        mode <= `MODE_DEEP_SLEEP;
        deep <= 32'h10000040;
        settle(9'h0C0, 1'b0);
        rd(`POWER_MODE_OFFSET, 32'h00000002, `RESP_OKAY);
        @(posedge aclk);
        mode <= 2'h3;
        settle(9'h085, 1'b0);
        rd(12'h300, 32'h00000000, `RESP_SLVERR);
        wr(12'h300, 32'h00000001, `RESP_SLVERR);
        rd(`RUN_GATE_OFFSET, 32'h10000005, `RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RUN_GATE_OFFSET, `GATE_RESET, `RESP_OKAY);
        settle(9'h000, 1'b0);
        final_report;
    end
endmodule // peripheral_clock_gate_run_sleep_test
`default_nettype wire
